// ===== sim/parallel_tdm_port_timing_test.sv
// self-checking bench for the parallel tdm port timing block
`default_nettype none
module parallel_tdm_port_timing_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk, arst_n, conversion_direction, edge_drive_select;
   logic       clock_phase_select, drive_en, p_oe, q_prev, stb_prev;
   logic [7:0] tx_byte, drive_byte, p_out, seen_byte, bus_wire;
   logic       master_clock_in, reference_clock_in, frame_pulse_in_n;
   logic [7:0] parallel_data_bus_value, rx_byte;
   logic       parallel_data_bus_en, slot_strobe, rx_valid;
   logic       quarter, eighth, frame_pulse_out_n, dmfp;
   int         err_total, cmp_count, cyc, qcnt, last_rise;

   // pull-ups win when nobody drives
   assign bus_wire = parallel_data_bus_en ? parallel_data_bus_value :
                     (p_oe ? p_out : 8'hff);

   ptdm_port ptdm_port_i (.core_clk(core_clk), .arst_n(arst_n),
      .master_clock_in(master_clock_in),
      .reference_clock_in(reference_clock_in),
      .frame_pulse_in_n(frame_pulse_in_n),
      .conversion_direction(conversion_direction),
      .edge_drive_select(edge_drive_select),
      .clock_phase_select(clock_phase_select),
      .parallel_data_bus_sense(bus_wire),
      .parallel_data_bus_value(parallel_data_bus_value),
      .parallel_data_bus_en(parallel_data_bus_en), .tx_byte(tx_byte),
      .slot_strobe(slot_strobe), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .quarter_rate_clock_out(quarter), .eighth_rate_clock_out(eighth),
      .frame_pulse_out_n(frame_pulse_out_n),
      .data_memory_frame_pulse(dmfp));

   ptdm_far_model ptdm_far_model_i (.master_clock_in(master_clock_in),
      .reference_clock_in(reference_clock_in),
      .frame_pulse_in_n(frame_pulse_in_n), .drive_en(drive_en),
      .drive_byte(drive_byte), .bus_out(p_out), .bus_oe(p_oe),
      .bus_level(bus_wire), .seen_byte(seen_byte));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // cycles since the quarter clock last rose
   always @(posedge core_clk) begin
      cyc    <= cyc + 1;
      q_prev <= quarter;
      stb_prev <= slot_strobe;
      qcnt   <= (quarter === 1'b1 && q_prev === 1'b0) ? 0 : qcnt + 1;
   end

   task automatic tally_and_finish;
      if (err_total == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input bit ok, input string msg);
      cmp_count++;
      if (!ok) begin
         err_total++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   function automatic bit near(input int a, input int b, input int tol);
      return a >= b - tol && a <= b + tol;
   endfunction

   function automatic int cdist(input int a, input int b);
      int d;
      d = (a - b + 48) % 24;
      return (d > 12) ? 24 - d : d;
   endfunction

   function automatic logic sig(input int w);
      case (w)
         0: return frame_pulse_out_n;
         1: return rx_valid;
         2: return parallel_data_bus_en;
         3: return quarter;
         default: return eighth;
      endcase
   endfunction

   task automatic wait_sig(input int w, input logic lvl, input int lim);
      for (int n = 0; n < lim; n++) begin
         @(negedge core_clk);
         if (sig(w) === lvl) return;
      end
      chk(1'b0, "wait timed out");
      tally_and_finish();
   endtask

   task automatic set_mode(input logic dir, input logic sel, input logic ph);
      @(posedge core_clk);
      conversion_direction <= dir;
      edge_drive_select    <= sel;
      clock_phase_select   <= ph;
      drive_en             <= dir;
   endtask

   task automatic s_align;
      int   t  = 0;
      int   qf = -1;
      int   er = -1;
      logic qp, ep;
      // skip the short pulses after reset and at the first realign
      wait_sig(0, 1'b0, 200);
      wait_sig(0, 1'b1, 200);
      wait_sig(0, 1'b0, 30000);
      wait_sig(0, 1'b1, 200);
      wait_sig(0, 1'b0, 30000);
      qp = quarter;
      ep = eighth;
      while (frame_pulse_out_n === 1'b0 && t < 100) begin
         @(negedge core_clk);
         t++;
         if (qp === 1'b1 && quarter === 1'b0) qf = t;
         if (ep === 1'b0 && eighth === 1'b1) er = t;
         qp = quarter;
         ep = eighth;
      end
      chk(near(qf, 24, 1), "quarter fall off centre");
      chk(near(er, 24, 1), "eighth rise off centre");
      chk(near(t, 48, 1), "frame pulse width");
   endtask

   task automatic s_dmfp(input logic ph, input int exp);
      int   t = 0;
      logic d0;
      @(posedge core_clk);
      clock_phase_select <= ph;
      wait_sig(0, 1'b0, 30000);
      wait_sig(0, 1'b1, 100);
      if (last_rise > 0) begin
         chk(near(cyc - last_rise, 24576, 1), "frame");
      end
      last_rise = cyc;
      d0 = dmfp;
      while (dmfp === d0 && t < 900) begin
         @(negedge core_clk);
         t++;
      end
      chk(near(t, exp, 1), "memory frame pulse delay");
   endtask

   task automatic s_period(input int w, input int exp);
      int t0;
      wait_sig(w, 1'b0, 200);
      wait_sig(w, 1'b1, 200);
      t0 = cyc;
      wait_sig(w, 1'b0, 200);
      wait_sig(w, 1'b1, 200);
      chk(near(cyc - t0, exp, 1), "derived clock period");
   endtask

   task automatic s_capture(input logic sel, input logic ph, input [7:0] b);
      int t0;
      set_mode(1'b1, sel, ph);
      drive_byte <= b;
      wait_sig(1, 1'b1, 60);
      wait_sig(1, 1'b0, 60);
      wait_sig(1, 1'b1, 60);
      chk(rx_byte === b, "captured byte");
      chk(parallel_data_bus_en === 1'b0, "bus driven as input");
      t0 = (sel ? 11 : 17) + (ph ? 12 : 0);
      chk(cdist(qcnt % 24, t0) <= 2, "capture edge");
      t0 = cyc;
      wait_sig(1, 1'b0, 60);
      wait_sig(1, 1'b1, 60);
      chk(cyc - t0 == 24, "capture spacing");
   endtask

   task automatic s_drive(input logic sel, input logic ph, input [7:0] b);
      int t0;
      set_mode(1'b0, sel, ph);
      tx_byte <= b;
      wait_sig(2, 1'b0, 60);
      wait_sig(2, 1'b1, 60);
      t0 = (sel ? 23 : 5) + (ph ? 12 : 0);
      chk(cdist(qcnt % 24, t0) <= 2, "launch edge");
      chk(parallel_data_bus_value === b, "driven byte");
      chk(stb_prev === 1'b1 && slot_strobe === 1'b0, "launch strobe");
      t0 = cyc;
      wait_sig(2, 1'b0, 60);
      chk(near(cyc - t0, sel ? 18 : 12, 1), "drive window");
      chk(seen_byte === b, "byte seen on bus");
      wait_sig(2, 1'b1, 60);
      chk(cyc - t0 == 24, "one launch per slot");
   endtask

   initial begin
      arst_n               = 1'b0;
      conversion_direction = 1'b1;
      edge_drive_select    = 1'b0;
      clock_phase_select   = 1'b0;
      drive_en             = 1'b1;
      drive_byte           = 8'h00;
      tx_byte              = 8'h00;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      s_align();
      s_dmfp(1'b0, 744);
      s_period(3, 48);
      s_period(4, 96);
      s_capture(1'b0, 1'b0, 8'ha5);
      s_capture(1'b1, 1'b0, 8'h5a);
      s_drive(1'b0, 1'b0, 8'h3c);
      s_drive(1'b1, 1'b0, 8'hc3);
      s_capture(1'b0, 1'b1, 8'h0f);
      s_capture(1'b1, 1'b1, 8'hf0);
      s_drive(1'b0, 1'b1, 8'h69);
      s_drive(1'b1, 1'b1, 8'h96);
      s_dmfp(1'b1, 756);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ===== sim/ptdm_far_model.sv
// far-side bus device model: timing source, bus byte source and sink
`default_nettype none
module ptdm_far_model (
   // timing outputs
   output logic             master_clock_in,
   output logic             reference_clock_in,
   output logic             frame_pulse_in_n,
   // bus source
   input  wire logic        drive_en,
   input  wire logic  [7:0] drive_byte,
   output logic       [7:0] bus_out,
   output logic             bus_oe,
   // bus sink
   input  wire logic  [7:0] bus_level,
   output logic       [7:0] seen_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   int mcount;
   assign bus_oe  = drive_en;
   assign bus_out = drive_byte;
   initial begin
      master_clock_in    = 1'b0;
      reference_clock_in = 1'b1;
      frame_pulse_in_n   = 1'b1;
      seen_byte          = 8'h00;
      mcount             = 2000;
      #13;
      forever begin
         #300;
         master_clock_in = 1'b1;
         mcount = (mcount + 1) % 2048;
         // reference is master/4 on the same rising edges
         reference_clock_in = mcount[1];
         // pulse falls two periods before the reference fall at the boundary
         frame_pulse_in_n = !(mcount >= 2046 || mcount <= 1);
         seen_byte = bus_level;
         #300;
         master_clock_in = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== src/ptdm_clkgen.sv
// frame counter, derived clocks and frame pulses
`default_nettype none
module ptdm_clkgen (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   // timing
   ptdm_tim_if.gen   tim
);
   logic [ptdm_pkg::CNT_W-1:0] cnt_ff;
   logic                       quarter_ff;
   logic                       eighth_ff;
   logic                       fp_n_ff;
   logic                       dmfp_ff;
   logic [ptdm_pkg::CNT_W-1:0] dmfp_pre;

   // free-running, realigned at each boundary
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= '0;
      end else if (tim.frame_start) begin
         cnt_ff <= '0;
      end else if (tim.mc_rise) begin
         cnt_ff <= cnt_ff + 11'h001;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         quarter_ff <= 1'b0;
         eighth_ff  <= 1'b0;
         fp_n_ff    <= 1'b1;
      end else begin
         quarter_ff <= cnt_ff[ptdm_pkg::QTR_BIT];
         eighth_ff  <= ~cnt_ff[ptdm_pkg::EIGHTH_BIT];
         fp_n_ff    <= !(cnt_ff >= ptdm_pkg::FP_LO_FROM ||
                         cnt_ff <  ptdm_pkg::FP_LO_TO);
      end
   end

   assign dmfp_pre = tim.phase_sel ? ptdm_pkg::DMFP_PRE1
                                   : ptdm_pkg::DMFP_PRE0;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dmfp_ff <= 1'b0;
      end else if (tim.mc_rise && !tim.frame_start && cnt_ff == dmfp_pre) begin
         dmfp_ff <= ~dmfp_ff;
      end
   end

   assign tim.cnt     = cnt_ff;
   assign tim.quarter = quarter_ff;
   assign tim.eighth  = eighth_ff;
   assign tim.fp_n    = fp_n_ff;
   assign tim.dmfp    = dmfp_ff;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_quarter_fall_mid: assert property (
      cnt_ff == '0 && $past(cnt_ff) == ptdm_pkg::FRAME_LAST |=>
      $fell(quarter_ff) && !fp_n_ff)
      else $error("quarter clock fell outside frame pulse");
   a_eighth_rise_mid: assert property ($rose(eighth_ff) |->
      (fp_n_ff == (cnt_ff != '0 && $past(cnt_ff) != '0)))
      else $error("eighth clock rose off frame pulse centre");
   a_dmfp_delay_cnt: assert property ($changed(dmfp_ff) |->
      $past(cnt_ff) == (tim.phase_sel ? ptdm_pkg::DMFP_PRE1
                                      : ptdm_pkg::DMFP_PRE0))
      else $error("memory frame pulse toggled at wrong count");
   a_realign_count: assert property (tim.frame_start |=> cnt_ff == '0)
      else $error("counter not realigned at frame boundary");
   a_quarter_divide: assert property (
      tim.mc_rise && !tim.frame_start && cnt_ff[0] |=>
      quarter_ff == $past(quarter_ff) ##1 quarter_ff != $past(quarter_ff,2))
      else $error("quarter clock not a divide by four");
   c_dmfp_toggle: cover property ($changed(dmfp_ff));
endmodule
`default_nettype wire

// ===== src/ptdm_pkg.sv
// constants and types for the parallel tdm port timing block
// Operation
// - make a quarter-rate clock output by dividing the master clock.
// - quarter-rate clock falls at the middle of the frame pulse output.
// - make an eighth-rate clock output by dividing the master clock.
// - eighth-rate clock rises at the middle of the frame pulse output.
// - edge/drive select picks latch edge or drive window per direction.
// - input mode, select low: capture byte on every second master fall.
// - input mode, select high: capture byte on every other master rise.
// - parallel-out with select low: drive from first falling edge to next.
// - output mode, select high: drive whole slot, first rise to last edge.
// - bus is output in serial-to-parallel, input in parallel-to-serial.
// - bus data moves only on master clock edges, never derived clocks.
// - clock-phase select shifts latch and launch edges against the frame.
// - frame boundary is first reference falling edge after frame pulse falls.
// - regenerate frame pulse on master clock, aligned to quarter clock.
// - memory frame pulse toggles 64 or 65 master cycles after the boundary.
`default_nettype none
package ptdm_pkg;
   localparam int unsigned BUS_W      = 8;
   localparam int unsigned CNT_W      = 11;
   // counter value at the last master cycle of one 8 kHz frame
   localparam logic [10:0] FRAME_LAST = 11'h7ff;
   // frame pulse output is low for four master cycles around the boundary
   localparam logic [10:0] FP_LO_FROM = 11'h7fe;
   localparam logic [10:0] FP_LO_TO   = 11'h002;
   localparam int unsigned QTR_BIT    = 1;
   localparam int unsigned EIGHTH_BIT = 2;
   // memory frame pulse toggle point, one cycle before the target count
   localparam logic [10:0] DMFP_PRE0  = 11'h03f;
   localparam logic [10:0] DMFP_PRE1  = 11'h040;
   localparam int unsigned SYNC_MSB   = 1;

   typedef enum logic {
      DRV_IDLE = 1'b0,
      DRV_ON   = 1'b1
   } ptdm_drv_t;
endpackage
`default_nettype wire

// ===== src/ptdm_port.sv
// parallel tdm port: bus capture and drive timing, derived clock outputs
`default_nettype none
module ptdm_port (
   // clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          arst_n,
   // timing pins
   input  wire logic                          master_clock_in,
   input  wire logic                          reference_clock_in,
   input  wire logic                          frame_pulse_in_n,
   // mode pins
   input  wire logic                          conversion_direction,
   input  wire logic                          edge_drive_select,
   input  wire logic                          clock_phase_select,
   // parallel bus
   input  wire logic [ptdm_pkg::BUS_W-1:0]    parallel_data_bus_sense,
   output logic      [ptdm_pkg::BUS_W-1:0]    parallel_data_bus_value,
   output logic                               parallel_data_bus_en,
   // serial-side user port
   input  wire logic [ptdm_pkg::BUS_W-1:0]    tx_byte,
   output logic                               slot_strobe,
   output logic      [ptdm_pkg::BUS_W-1:0]    rx_byte,
   output logic                               rx_valid,
   // derived outputs
   output logic                               quarter_rate_clock_out,
   output logic                               eighth_rate_clock_out,
   output logic                               frame_pulse_out_n,
   output logic                               data_memory_frame_pulse
);
   ptdm_tim_if tim ();

   logic [2:0]                    mc_sync_ff;
   logic [2:0]                    ref_sync_ff;
   logic [2:0]                    fp_sync_ff;
   logic [1:0]                    dir_sync_ff;
   logic [1:0]                    eds_sync_ff;
   logic [1:0]                    cps_sync_ff;
   logic [ptdm_pkg::BUS_W-1:0]    bus_s1_ff;
   logic [ptdm_pkg::BUS_W-1:0]    bus_s2_ff;
   logic                          fp_armed_ff;
   logic                          frame_start;
   logic                          dir_in;
   logic                          eds;
   logic                          cps;
   logic                          mc_rise;
   logic                          mc_fall;
   logic                          cap_evt;
   logic                          launch_evt;
   logic                          release_evt;
   ptdm_pkg::ptdm_drv_t           drv_ff;
   ptdm_pkg::ptdm_drv_t           nxt_drv;
   logic [ptdm_pkg::BUS_W-1:0]    value_ff;
   logic [ptdm_pkg::BUS_W-1:0]    rx_byte_ff;
   logic                          rx_valid_ff;

   // first-stage flops feed only the second stage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mc_sync_ff  <= '0;
         ref_sync_ff <= '0;
         fp_sync_ff  <= 3'h7;
      end else begin
         mc_sync_ff  <= {mc_sync_ff[1:0], master_clock_in};
         ref_sync_ff <= {ref_sync_ff[1:0], reference_clock_in};
         fp_sync_ff  <= {fp_sync_ff[1:0], frame_pulse_in_n};
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_sync_ff <= '0;
         eds_sync_ff <= '0;
         cps_sync_ff <= '0;
         bus_s1_ff   <= '0;
         bus_s2_ff   <= '0;
      end else begin
         dir_sync_ff <= {dir_sync_ff[0], conversion_direction};
         eds_sync_ff <= {eds_sync_ff[0], edge_drive_select};
         cps_sync_ff <= {cps_sync_ff[0], clock_phase_select};
         bus_s1_ff   <= parallel_data_bus_sense;
         bus_s2_ff   <= bus_s1_ff;
      end
   end

   assign dir_in  = dir_sync_ff[ptdm_pkg::SYNC_MSB];
   assign eds     = eds_sync_ff[ptdm_pkg::SYNC_MSB];
   assign cps     = cps_sync_ff[ptdm_pkg::SYNC_MSB];
   // bus data moves on master clock edges only
   assign mc_rise = mc_sync_ff[1] & ~mc_sync_ff[2];
   assign mc_fall = ~mc_sync_ff[1] & mc_sync_ff[2];

   // boundary: first reference fall after frame pulse fall
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fp_armed_ff <= 1'b0;
      end else if (~fp_sync_ff[1] & fp_sync_ff[2]) begin
         fp_armed_ff <= 1'b1;
      end else if (frame_start) begin
         fp_armed_ff <= 1'b0;
      end
   end

   assign frame_start = fp_armed_ff & ~ref_sync_ff[1]
                        & ref_sync_ff[2];

   // true when the master period index is the first half of a slot
   function automatic logic slot_head(
      input logic [ptdm_pkg::CNT_W-1:0] cnt,
      input logic                       rise,
      input logic                       phase
   );
      logic [ptdm_pkg::CNT_W-1:0] idx;
      idx = rise ? cnt + 11'h001 : cnt;
      return idx[0] == phase;
   endfunction

   // select picks latch edge or drive window by direction
   always_comb begin
      cap_evt     = 1'b0;
      launch_evt  = 1'b0;
      release_evt = 1'b0;
      if (dir_in) begin
         if (eds) begin
            cap_evt = mc_rise && !slot_head(tim.cnt, 1'b1, cps);
         end else begin
            cap_evt = mc_fall && !slot_head(tim.cnt, 1'b0, cps);
         end
      end else begin
         if (eds) begin
            launch_evt = mc_rise && slot_head(tim.cnt, 1'b1, cps);
         end else begin
            launch_evt = mc_fall && slot_head(tim.cnt, 1'b0, cps);
         end
         release_evt = mc_fall && !slot_head(tim.cnt, 1'b0, cps);
      end
   end

   always_comb begin
      nxt_drv = drv_ff;
      case (drv_ff)
         ptdm_pkg::DRV_IDLE: begin
            if (launch_evt) begin
               nxt_drv = ptdm_pkg::DRV_ON;
            end
         end
         ptdm_pkg::DRV_ON: begin
            if (dir_in || release_evt) begin
               nxt_drv = ptdm_pkg::DRV_IDLE;
            end
         end
         default: nxt_drv = ptdm_pkg::DRV_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         drv_ff <= ptdm_pkg::DRV_IDLE;
      end else begin
         drv_ff <= nxt_drv;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         value_ff <= '0;
      end else if (launch_evt) begin
         value_ff <= tx_byte;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_byte_ff  <= '0;
         rx_valid_ff <= 1'b0;
      end else begin
         rx_valid_ff <= cap_evt;
         if (cap_evt) begin
            rx_byte_ff <= bus_s2_ff;
         end
      end
   end

   assign tim.mc_rise     = mc_rise;
   assign tim.mc_fall     = mc_fall;
   assign tim.frame_start = frame_start;
   assign tim.phase_sel   = cps;

   ptdm_clkgen ptdm_clkgen_i (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .tim      (tim)
   );

   assign parallel_data_bus_value = value_ff;
   assign parallel_data_bus_en    = (drv_ff == ptdm_pkg::DRV_ON);
   assign slot_strobe             = launch_evt;
   assign rx_byte                 = rx_byte_ff;
   assign rx_valid                = rx_valid_ff;
   assign quarter_rate_clock_out  = tim.quarter;
   assign eighth_rate_clock_out   = tim.eighth;
   assign frame_pulse_out_n       = tim.fp_n;
   assign data_memory_frame_pulse = tim.dmfp;

   // checks
   logic cap_head;
   assign cap_head = slot_head(tim.cnt, mc_rise, cps);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_input_no_drive: assert property (
      dir_in && $past(dir_in) |-> !parallel_data_bus_en)
      else $error("bus driven while it is an input");
   a_capture_edge_sel: assert property (
      rx_valid_ff |-> $past(eds ? mc_rise : mc_fall) && $past(dir_in))
      else $error("capture on wrong master edge");
   a_capture_data: assert property (
      rx_valid_ff |-> rx_byte_ff == $past(bus_s2_ff))
      else $error("captured byte differs from bus");
   a_capture_phase: assert property (
      cap_evt |-> !cap_head)
      else $error("capture in first half of slot");
   a_half_slot_drive: assert property (
      $rose(parallel_data_bus_en) && !$past(eds) |-> $past(mc_fall))
      else $error("half slot drive not launched on fall");
   a_full_slot_drive: assert property (
      $rose(parallel_data_bus_en) && $past(eds) |-> $past(mc_rise))
      else $error("full slot drive not launched on rise");
   a_drive_release: assert property (
      $fell(parallel_data_bus_en) |-> $past(mc_fall || dir_in))
      else $error("bus released off a falling edge");
   a_launch_data: assert property (
      $rose(parallel_data_bus_en) |->
      parallel_data_bus_value == $past(tx_byte))
      else $error("launched byte differs from source");
   a_rx_one_pulse: assert property (
      rx_valid_ff |=> !rx_valid_ff)
      else $error("capture strobe longer than one cycle");
   a_boundary_armed: assert property (
      frame_start |-> $past(fp_armed_ff) ##1
      (!fp_armed_ff || $past(~fp_sync_ff[1] & fp_sync_ff[2])))
      else $error("boundary without prior frame pulse");

   c_capture_rise: cover property (rx_valid_ff && eds);
   c_capture_fall: cover property (rx_valid_ff && !eds);
   c_drive_window: cover property (
      $rose(parallel_data_bus_en) ##[1:20] $fell(parallel_data_bus_en));
   c_frame_start: cover property (frame_start);
endmodule
`default_nettype wire

// ===== src/ptdm_port_fix.sv
// empty unit: the block's logic lives in the port and clock generator
`default_nettype none
`default_nettype wire

// ===== src/ptdm_tim_if.sv
// timing signals shared between the port and the clock generator
`default_nettype none
interface ptdm_tim_if;
   logic                              mc_rise;
   logic                              mc_fall;
   logic                              frame_start;
   logic                              phase_sel;
   logic [ptdm_pkg::CNT_W-1:0]        cnt;
   logic                              quarter;
   logic                              eighth;
   logic                              fp_n;
   logic                              dmfp;
   modport gen  (input mc_rise, mc_fall, frame_start, phase_sel,
                 output cnt, quarter, eighth, fp_n, dmfp);
   modport port (output mc_rise, mc_fall, frame_start, phase_sel,
                 input cnt, quarter, eighth, fp_n, dmfp);
endinterface
`default_nettype wire
